// *** hw/mcf_buf2.sv ***
`timescale 1ns/1ns
module mcf_buf2 #(
  parameter int W = 30
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] tail;
  logic tail_v;
  wire push = in_valid & ~tail_v;
  wire pop = out_valid & out_ready;

  assign in_ready = ~tail_v;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      tail_v <= 1'b0;
      out_data <= '0;
      tail <= '0;
    end else if (ce) begin
      if (pop && push) begin
        out_data <= in_data;
      end else if (pop) begin
        out_data <= tail;
        out_valid <= tail_v;
        tail_v <= 1'b0;
      end else if (push && !out_valid) begin
        out_data <= in_data;
        out_valid <= 1'b1;
      end else if (push) begin
        tail <= in_data;
        tail_v <= 1'b1;
      end
    end
  end
endmodule : mcf_buf2

// *** hw/mcf_dev.sv ***
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ns
module mcf_dev #(
  parameter int FW_SHOW = mcf_pkg::FW_SHOW_CYC,
  parameter logic [7:0] FW_VER = 8'h01, // value arbitrary
  parameter int NPORT = 32
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link
  mcf_link_if.dev link,
  // aes side, index = port * 2 + subframe
  input wire logic aes_in_valid,
  output logic aes_in_ready,
  input wire logic [5:0] aes_in_idx,
  input wire logic [23:0] aes_in_data,
  input wire logic aes_fs_tick,
  output logic aes_out_valid,
  input wire logic aes_out_ready,
  output logic [5:0] aes_out_idx,
  output logic [23:0] aes_out_data,
  output logic aes_out_pro,
  // side channels
  input wire logic [8:0] rs_tx_bits,
  input wire logic midi_tx_bit,
  output logic [8:0] rs_rx_bits,
  output logic rs_rx_stb,
  output logic midi_rx_bit,
  output logic midi_rx_stb,
  input wire logic [1:0] nv_baud,
  output logic [1:0] baud_sel,
  // clock reference and indicators
  input wire logic wclk_in,
  output logic [7:0] led_sync,
  output logic [7:0] led_audio
);
  import mcf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pins from outside pass two flops; only s2 is read
  logic [3:0] s1;
  logic [3:0] s2;
  logic l_prev;
  logic w_prev;
  wire [3:0] pins = {wclk_in, link.h2d_sync, link.h2d_data, link.lclk};
  wire l_rise = s2[0] & ~l_prev;
  wire w_rise = s2[3] & ~w_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 4'h0;
      s2 <= 4'h0;
      l_prev <= 1'b0;
      w_prev <= 1'b0;
    end else if (ce) begin
      s1 <= pins;
      s2 <= s1;
      l_prev <= s2[0];
      w_prev <= s2[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  mcf_fmt_t tx_fmt;
  mcf_wire_t wmode;
  mcf_src_t src;
  mcf_fmt_t rx_fmt;
  mcf_spd_t wc_spd;
  logic rx_lock;
  logic rx_ovr;
  logic fw_on;
  logic binit;
  wire setup = psel & ~penable;
  wire hit_ctrl = paddr == REG_CTRL;
  wire hit_stat = paddr == REG_STAT;
  wire done = psel & penable & pready;
  wire wr_ctrl = done & pwrite & hit_ctrl;
  wire rd_stat = done & ~pwrite & hit_stat;
  wire [31:0] ctrl_word = (32'(tx_fmt) << CTRL_FMT_LSB) | (32'(wmode) << CTRL_WIRE_LSB)
                        | (32'(src) << CTRL_SRC_LSB) | (32'(baud_sel) << CTRL_BAUD_LSB);
  wire [31:0] stat_word = (32'(rx_fmt) << STAT_FMT_LSB) | (32'(wc_spd) << STAT_WC_LSB)
                        | (32'(rx_lock) << STAT_LOCK_BIT) | (32'(rx_ovr) << STAT_OVR_BIT)
                        | (32'(fw_on) << STAT_FW_BIT);
  wire [31:0] rd_word = hit_ctrl ? ctrl_word : hit_stat ? stat_word : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      tx_fmt <= CTRL_FMT_RST;
      wmode <= CTRL_WIRE_RST;
      src <= CTRL_SRC_RST;
      baud_sel <= BAUD_9600;
      binit <= 1'b0;
    end else if (ce) begin
      pready <= setup & ~pready;
      pslverr <= setup & ~(hit_ctrl | hit_stat);
      prdata <= setup ? rd_word : 32'h00000000;
      binit <= 1'b1;
      if (!binit) begin
        // rate comes back from the stored setting after every restart
        baud_sel <= nv_baud;
      end else if (wr_ctrl) begin
        baud_sel <= pwdata[CTRL_BAUD_LSB +: 2];
      end
      if (wr_ctrl) begin
        tx_fmt <= mcf_fmt_t'(pwdata[CTRL_FMT_LSB +: 2]);
        wmode <= mcf_wire_t'(pwdata[CTRL_WIRE_LSB +: 2]);
        src <= mcf_src_t'(pwdata[CTRL_SRC_LSB +: 2]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link receive and frame format detection
  logic [30:0] rsr;
  logic [4:0] rbit;
  logic [6:0] rch;
  logic rf96;
  logic madi_sof;
  logic rx_wv;
  logic [31:0] rx_w;
  logic [5:0] rx_ch;
  wire [31:0] rword = {rsr, s2[1]};
  wire len_48 = (rch == 7'(CH_56)) || (rch == 7'(CH_64));
  wire len_96 = (rch == 7'(CH_96_56)) || (rch == 7'(CH_96));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsr <= 31'h00000000;
      rbit <= 5'h00;
      rch <= 7'h00;
      rf96 <= 1'b0;
      madi_sof <= 1'b0;
      rx_wv <= 1'b0;
      rx_w <= 32'h00000000;
      rx_ch <= 6'h00;
      rx_lock <= 1'b0;
      rx_fmt <= CTRL_FMT_RST;
    end else if (ce) begin
      madi_sof <= 1'b0;
      rx_wv <= 1'b0;
      if (l_rise) begin
        rsr <= rword[30:0];
        rbit <= s2[2] ? 5'h01 : rbit + 5'h01;
        if (s2[2]) begin
          // judge the frame that just ended by its length and 96k flag
          madi_sof <= 1'b1;
          rch <= 7'h00;
          rf96 <= 1'b0;
          rx_lock <= rf96 ? len_96 : len_48;
          if (rf96 ? len_96 : len_48) begin
            rx_fmt <= rf96 ? fmt_96 : (rch == 7'(CH_56)) ? fmt_56 : fmt_64;
          end
        end else if (rbit == 5'h1F) begin
          rx_wv <= 1'b1;
          rx_w <= rword;
          rx_ch <= rch[5:0];
          rch <= rch + 7'h01;
          rf96 <= rf96 | rword[F96_BIT];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // side channel extraction and channel regrouping
  logic [1:0] shf;
  logic brdy;
  assign shf = (wmode == wire_4) ? 2'h2 : (wmode == wire_2) ? 2'h1 : 2'h0;
  wire [1:0] pmask = {shf[1], |shf};
  wire [5:0] midi_ch = (rx_fmt == fmt_96) ? 6'(MIDI_CH96) : 6'(MIDI_CH48);
  // consecutive channels carry consecutive samples of one aes channel
  wire [5:0] aes_oidx = rx_ch >> shf;
  wire [29:0] buf_in = {aes_oidx, rx_w[AUDIO_W-1:0]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rs_rx_bits <= 9'h000;
      rs_rx_stb <= 1'b0;
      midi_rx_bit <= 1'b0;
      midi_rx_stb <= 1'b0;
      rx_ovr <= 1'b0;
      aes_out_pro <= 1'b0;
    end else if (ce) begin
      aes_out_pro <= 1'b1;
      rx_ovr <= (rx_wv & ~brdy) | (rx_ovr & ~rd_stat);
      rs_rx_stb <= rx_wv && (rx_ch == 6'(RS_LAST));
      midi_rx_stb <= rx_wv && (rx_ch == midi_ch);
      if (rx_wv && rx_ch <= 6'(RS_LAST)) begin
        rs_rx_bits[rx_ch[3:0]] <= rx_w[USER_BIT];
      end
      if (rx_wv && rx_ch == midi_ch) begin
        midi_rx_bit <= rx_w[USER_BIT];
      end
    end
  end

  // a full buffer drops the word and raises the overrun flag
  mcf_buf2 #(.W(30)) u_outbuf (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .in_valid(rx_wv),
    .in_ready(brdy),
    .in_data(buf_in),
    .out_valid(aes_out_valid),
    .out_ready(aes_out_ready),
    .out_data({aes_out_idx, aes_out_data})
  );

  ////////////////////////////////////////////////////////////////////////////
  // sample clock sources
  logic [15:0] icnt;
  logic [15:0] wper;
  logic [1:0] wdiv;
  logic int_tick;
  logic wc_tick;
  logic sel_tick;
  wire [1:0] wmask = (wc_spd == spd_4) ? 2'h3 : (wc_spd == spd_2) ? 2'h1 : 2'h0;
  assign sel_tick = (src == src_int) ? int_tick : (src == src_aes) ? aes_fs_tick
                  : (src == src_madi) ? madi_sof : wc_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      icnt <= 16'h0000;
      int_tick <= 1'b0;
      wper <= 16'h0000;
      wdiv <= 2'h0;
      wc_tick <= 1'b0;
      wc_spd <= spd_1;
    end else if (ce) begin
      int_tick <= icnt == 16'(INT_DIV - 1);
      icnt <= (icnt == 16'(INT_DIV - 1)) ? 16'h0000 : icnt + 16'h0001;
      wc_tick <= w_rise && (wdiv == 2'h0);
      if (w_rise) begin
        // short periods mean a double or quad rate reference
        wc_spd <= (wper < 16'(WC_QUAD_CYC)) ? spd_4
                : (wper < 16'(WC_DBL_CYC)) ? spd_2 : spd_1;
        wdiv <= (wdiv + 2'h1) & wmask;
        wper <= 16'h0000;
      end else if (wper != 16'hFFFF) begin
        wper <= wper + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // aes input to channel memory, then a frame at the link rise after a pending sample tick; ticks during a frame merge into one
  logic [23:0] txmem [64];
  logic [1:0] tph [64];
  logic tpend;
  logic tact;
  logic [6:0] tch;
  logic [4:0] tbit;
  // channel status flags are not inspected, so copy protection has no effect
  wire acc = aes_in_valid & aes_in_ready;
  wire [5:0] tx_mch = 6'(aes_in_idx << shf) | {4'h0, tph[aes_in_idx] & pmask};
  wire [6:0] tnch = (tx_fmt == fmt_56) ? 7'(CH_56)
                  : (tx_fmt == fmt_64) ? 7'(CH_64) : 7'(CH_96);
  wire [5:0] tmidi = (tx_fmt == fmt_96) ? 6'(MIDI_CH96) : 6'(MIDI_CH48);
  wire tub = (tch <= 7'(RS_LAST)) ? rs_tx_bits[tch[3:0]]
           : (tch[5:0] == tmidi) & midi_tx_bit;
  wire [31:0] tword = {6'h00, tx_fmt == fmt_96, tub, txmem[tch[5:0]]};

  always_ff @(posedge pclk) begin
    if (ce && acc) begin
      // memory holds the latest sample per channel, one 24-bit entry for each of the 64 channels
      txmem[tx_mch] <= aes_in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 64; i++) begin
        tph[i] <= 2'h0;
      end
      aes_in_ready <= 1'b0;
      tpend <= 1'b0;
      tact <= 1'b0;
      tch <= 7'h00;
      tbit <= 5'h00;
      link.d2h_data <= 1'b0;
      link.d2h_sync <= 1'b0;
    end else if (ce) begin
      aes_in_ready <= 1'b1;
      if (acc) begin
        tph[aes_in_idx] <= (tph[aes_in_idx] + 2'h1) & pmask;
      end
      tpend <= sel_tick | (tpend & ~(l_rise & ~tact));
      if (l_rise) begin
        link.d2h_data <= tact & tword[~tbit];
        link.d2h_sync <= tact && (tch == 7'h00) && (tbit == 5'h00);
        if (tact) begin
          tbit <= tbit + 5'h01;
          if (tbit == 5'h1F) begin
            tch <= tch + 7'h01;
            // a format change in mid-frame must never run the count past the end
            tact <= tch < tnch - 7'h01;
          end
        end else if (tpend) begin
          tact <= 1'b1;
          tch <= 7'h00;
          tbit <= 5'h00;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indicators show the version first, then lock and activity
  logic [31:0] fwcnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwcnt <= 32'h00000000;
      fw_on <= 1'b1;
      led_sync <= 8'h00;
      led_audio <= 8'h00;
    end else if (ce) begin
      if (fw_on) begin
        fwcnt <= fwcnt + 32'h00000001;
        fw_on <= fwcnt != 32'(FW_SHOW - 1);
      end
      led_sync <= fw_on ? FW_VER : {6'h00, wc_spd != spd_1, rx_lock};
      led_audio <= fw_on ? FW_VER : {6'h00, tact, aes_out_valid};
    end
  end
endmodule : mcf_dev

// *** hw/mcf_host.sv ***
`timescale 1ns/1ns
module mcf_host #(
  parameter int LDIV = mcf_pkg::LINK_DIV
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // link
  mcf_link_if.host link,
  // frame format sent
  input wire mcf_pkg::mcf_fmt_t fmt,
  // words to send
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [23:0] tx_audio,
  input wire logic tx_user,
  // words received
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [5:0] rx_ch,
  output logic [31:0] rx_word,
  output logic rx_drop
);
  import mcf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] dcnt;
  logic lfall;
  logic [1:0] ds1;
  logic [1:0] ds2;
  wire dwrap = dcnt == 16'(LDIV / 2 - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcnt <= 16'h0000;
      link.lclk <= 1'b0;
      lfall <= 1'b0;
      ds1 <= 2'h0;
      ds2 <= 2'h0;
    end else if (ce) begin
      dcnt <= dwrap ? 16'h0000 : dcnt + 16'h0001;
      if (dwrap) begin
        link.lclk <= ~link.lclk;
      end
      lfall <= dwrap & link.lclk;
      // device pins are foreign: two flops before the receiver reads them
      ds1 <= {link.d2h_sync, link.d2h_data};
      ds2 <= ds1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit: frames follow back to back; a missing word goes out silent
  logic [24:0] hold;
  logic hvld;
  logic [31:0] hword;
  logic [6:0] hch;
  logic [4:0] hbit;
  wire acc = tx_valid & tx_ready;
  wire load = lfall & (hbit == 5'h00);
  wire next_hvld = (hvld & ~load) | acc;
  wire [6:0] hnch = fmt == fmt_56 ? 7'(CH_56) : fmt == fmt_64 ? 7'(CH_64) : 7'(CH_96);
  wire [31:0] hnew = {6'h00, fmt == fmt_96, hvld ? hold : 25'h0000000};
  wire [31:0] hcur = load ? hnew : hword;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold <= 25'h0000000;
      hvld <= 1'b0;
      tx_ready <= 1'b0;
      hword <= 32'h00000000;
      hch <= 7'h00;
      hbit <= 5'h00;
      link.h2d_data <= 1'b0;
      link.h2d_sync <= 1'b0;
    end else if (ce) begin
      hvld <= next_hvld;
      tx_ready <= ~next_hvld;
      if (acc) begin
        // user bit travels beside the audio, which is never touched
        hold <= {tx_user, tx_audio};
      end
      if (lfall) begin
        hword <= hcur;
        link.h2d_data <= hcur[~hbit];
        link.h2d_sync <= (hch == 7'h00) && (hbit == 5'h00);
        hbit <= hbit + 5'h01;
        if (hbit == 5'h1F) begin
          hch <= (hch >= hnch - 7'h01) ? 7'h00 : hch + 7'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive: words pass unchanged, spread samples keep their order
  logic [30:0] rsr;
  logic [4:0] rbit;
  logic [6:0] rch;
  logic rwv;
  logic [37:0] rwd;
  logic brdy;
  wire [31:0] rnew = {rsr, ds2[0]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsr <= 31'h00000000;
      rbit <= 5'h00;
      rch <= 7'h00;
      rwv <= 1'b0;
      rwd <= 38'h0000000000;
      rx_drop <= 1'b0;
    end else if (ce) begin
      rwv <= 1'b0;
      rx_drop <= rwv & ~brdy;
      if (lfall) begin
        rsr <= rnew[30:0];
        rbit <= ds2[1] ? 5'h01 : rbit + 5'h01;
        if (ds2[1]) begin
          rch <= 7'h00;
        end else if (rbit == 5'h1F) begin
          rwv <= 1'b1;
          rwd <= {rch[5:0], rnew};
          rch <= rch + 7'h01;
        end
      end
    end
  end

  mcf_buf2 #(.W(38)) u_rxbuf (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .in_valid(rwv),
    .in_ready(brdy),
    .in_data(rwd),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data({rx_ch, rx_word})
  );
endmodule : mcf_host

// *** pkg/mcf_link_if.sv ***
`timescale 1ns/1ns
interface mcf_link_if;
  logic lclk;
  logic h2d_data;
  logic h2d_sync;
  logic d2h_data;
  logic d2h_sync;
  modport host (output lclk, output h2d_data, output h2d_sync,
                input d2h_data, input d2h_sync);
  modport dev (input lclk, input h2d_data, input h2d_sync,
               output d2h_data, output d2h_sync);
endinterface : mcf_link_if

// *** pkg/mcf_pkg.sv ***
package mcf_pkg;
  // system clock and link pacing
  localparam int CLK_HZ = 50_000_000;
  localparam int LINK_DIV = 16;
  // channel word layout on the link, sent msb first
  localparam int AUDIO_W = 24;
  localparam int USER_BIT = 24;
  localparam int F96_BIT = 25;
  // frame lengths in channel words
  localparam int CH_56 = 56;
  localparam int CH_64 = 64;
  localparam int CH_96 = 32;
  localparam int CH_96_56 = 28;
  // side channels, zero-based channel numbers
  localparam int RS_LAST = 8;
  localparam int MIDI_CH48 = 55;
  localparam int MIDI_CH96 = 27;
  // sample clock sources
  localparam int FS_INT_HZ = 48_000;
  localparam int INT_DIV = CLK_HZ / FS_INT_HZ;
  localparam int WC_DBL_MIN_HZ = 72_000;
  localparam int WC_QUAD_MIN_HZ = 144_000;
  localparam int WC_DBL_CYC = CLK_HZ / WC_DBL_MIN_HZ;
  localparam int WC_QUAD_CYC = CLK_HZ / WC_QUAD_MIN_HZ;
  // power-on version display
  localparam int FW_SHOW_MS = 1000;
  localparam int FW_SHOW_CYC = CLK_HZ / 1000 * FW_SHOW_MS;
  // registers
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam int CTRL_FMT_LSB = 0;
  localparam int CTRL_WIRE_LSB = 2;
  localparam int CTRL_SRC_LSB = 4;
  localparam int CTRL_BAUD_LSB = 6;
  localparam int STAT_FMT_LSB = 0;
  localparam int STAT_WC_LSB = 2;
  localparam int STAT_LOCK_BIT = 4;
  localparam int STAT_OVR_BIT = 5;
  localparam int STAT_FW_BIT = 6;
  // serial side channel rate codes
  localparam logic [1:0] BAUD_9600 = 2'h0;
  localparam logic [1:0] BAUD_19200 = 2'h1;
  localparam logic [1:0] BAUD_38400 = 2'h3;
  localparam logic [1:0] BAUD_115200 = 2'h2;

  typedef enum logic [1:0] {fmt_56, fmt_64, fmt_96} mcf_fmt_t;
  typedef enum logic [1:0] {wire_1, wire_2, wire_4} mcf_wire_t;
  typedef enum logic [1:0] {src_int, src_aes, src_madi, src_wc} mcf_src_t;
  typedef enum logic [1:0] {spd_1, spd_2, spd_4} mcf_spd_t;

  localparam mcf_fmt_t CTRL_FMT_RST = fmt_64;
  localparam mcf_wire_t CTRL_WIRE_RST = wire_1;
  localparam mcf_src_t CTRL_SRC_RST = src_int;
endpackage : mcf_pkg

// *** verif/mcf_chk.sv ***
`timescale 1ns/1ns
module mcf_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link
  input wire logic lclk,
  input wire logic h2d_data,
  input wire logic h2d_sync,
  input wire logic d2h_data,
  input wire logic d2h_sync
);
  logic lq;
  logic hseen;
  logic [12:0] hcnt;
  wire rise = lclk && !lq;
  wire [12:0] hnext = hcnt + 13'h0001;
  wire [12:0] hcur = h2d_sync ? 13'h0000 : hnext;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  // bit position since the last host sync, counted on link rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lq <= 1'b0;
      hseen <= 1'b0;
      hcnt <= 13'h0000;
    end else begin
      lq <= lclk;
      if (rise) begin
        hseen <= hseen | h2d_sync;
        hcnt <= hcur;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  AST_LCLK_HIGH: assert property ($rose(lclk) |-> lclk [*8] ##1 !lclk)
    else $error("link clock high phase not 8 cycles");
  AST_LCLK_LOW: assert property ($fell(lclk) |-> !lclk [*8] ##1 lclk)
    else $error("link clock low phase not 8 cycles");
  AST_H2D_HOLD: assert property (lclk && $past(lclk) |-> $stable(h2d_data))
    else $error("host data moved while link clock high");
  AST_H2D_SYNC_HOLD: assert property (lclk && $past(lclk) |-> $stable(h2d_sync))
    else $error("host sync moved while link clock high");
  AST_D2H_HOLD: assert property (!lclk && !$past(lclk) |-> $stable(d2h_data))
    else $error("device data moved while link clock low");
  AST_D2H_SYNC_HOLD: assert property (!lclk && !$past(lclk) |-> $stable(d2h_sync))
    else $error("device sync moved while link clock low");
  // the six top bits of every word stay zero
  AST_H2D_PAD: assert property (rise && (hseen || h2d_sync) && hcur[4:0] < 5'h06 |-> !h2d_data)
    else $error("host word pad bit not zero");
  AST_H2D_FRAME: assert property (rise && h2d_sync && hseen |->
    hnext == 13'h0400 || hnext == 13'h0700 || hnext == 13'h0800)
    else $error("host frame length not 32, 56 or 64 words");
endmodule : mcf_chk

// *** verif/tb_madi_channel_format_mapper.sv ***
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_madi_channel_format_mapper;
  import mcf_pkg::*;
  localparam logic [7:0] FW = 8'h5E; // arbitrary value
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
  logic [7:0] paddr, led_sync, led_audio;
  logic [31:0] pwdata, prdata, rq, rx_word;
  logic aes_in_valid, aes_in_ready, aes_fs_tick, aes_out_valid, aes_out_ready, aes_out_pro;
  logic [5:0] aes_in_idx, rx_ch, aes_out_idx, imax = 6'h00;
  logic [23:0] aes_in_data, aes_out_data, tx_audio, last_aes;
  logic [8:0] rs_tx_bits, rs_rx_bits;
  logic midi_tx_bit, midi_rx_bit, wclk_in, tx_user, rx_valid, rx_ready, rx_drop;
  logic drop_seen = 1'b0, trk = 1'b0;
  logic rs_rx_stb, midi_rx_stb;
  logic [1:0] stb = 2'h0;
  logic [1:0] nvb, baud_sel;
  logic [1:0] codes [4] = '{BAUD_9600, BAUD_19200, BAUD_38400, BAUD_115200};
  logic [31:0] rxw [64];
  mcf_fmt_t fmt;
  int checks = 0, miscompares = 0, cyc = 0, wcnt = 0, wc_half = 260, nfe = 0, nch = 64;
  mcf_link_if mcf_link_if_i();
  mcf_host #(.LDIV(16)) mcf_host_i (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .link(mcf_link_if_i), .fmt(fmt), .tx_valid(1'b1), .tx_ready(), .tx_audio(tx_audio),
    .tx_user(tx_user), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_ch(rx_ch),
    .rx_word(rx_word), .rx_drop(rx_drop));
  mcf_dev #(.FW_SHOW(100), .FW_VER(FW)) mcf_dev_i (.pclk(pclk), .presetn(presetn),
    .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(mcf_link_if_i), .aes_in_valid(aes_in_valid), .aes_in_ready(aes_in_ready),
    .aes_in_idx(aes_in_idx), .aes_in_data(aes_in_data), .aes_fs_tick(aes_fs_tick),
    .aes_out_valid(aes_out_valid), .aes_out_ready(aes_out_ready), .aes_out_idx(aes_out_idx),
    .aes_out_data(aes_out_data), .aes_out_pro(aes_out_pro), .rs_tx_bits(rs_tx_bits),
    .midi_tx_bit(midi_tx_bit), .rs_rx_bits(rs_rx_bits), .rs_rx_stb(rs_rx_stb),
    .midi_rx_bit(midi_rx_bit), .midi_rx_stb(midi_rx_stb), .nv_baud(nvb), .baud_sel(baud_sel),
    .wclk_in(wclk_in), .led_sync(led_sync), .led_audio(led_audio));
  mcf_chk mcf_chk_i (.pclk(pclk), .presetn(presetn), .lclk(mcf_link_if_i.lclk),
    .h2d_data(mcf_link_if_i.h2d_data), .h2d_sync(mcf_link_if_i.h2d_sync),
    .d2h_data(mcf_link_if_i.d2h_data), .d2h_sync(mcf_link_if_i.d2h_sync));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // tick, word clock, receive capture and watchdog
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    aes_fs_tick <= (cyc % 1041 == 0);
    wcnt <= (wcnt >= wc_half - 1) ? 0 : wcnt + 1;
    if (wcnt >= wc_half - 1) wclk_in <= ~wclk_in;
    if (rx_valid && rx_ready) begin
      rxw[rx_ch] <= rx_word;
      if (rx_ch == nch - 1) nfe <= nfe + 1;
    end
    if (rx_drop) drop_seen <= 1'b1;
    if (aes_out_valid && aes_out_ready) last_aes <= aes_out_data;
    stb <= stb | {rs_rx_stb, midi_rx_stb};
    if (trk && aes_out_valid && aes_out_ready && aes_out_idx > imax) imax <= aes_out_idx;
    if (cyc == 100000) begin
      miscompares++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    `CHK(n, 1)
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic aes(input logic [5:0] i, input logic [23:0] v);
    @(posedge pclk);
    aes_in_valid <= 1'b1;
    aes_in_idx <= i;
    aes_in_data <= v;
    do @(posedge pclk); while (aes_in_ready !== 1'b1);
    aes_in_valid <= 1'b0;
  endtask : aes
  task automatic frames(input int n);
    int t;
    t = nfe + n;
    while (nfe < t) @(posedge pclk);
  endtask : frames
  task automatic stop_test();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {aes_in_valid, aes_in_idx, aes_in_data, aes_out_ready, rx_ready} = '0;
    {wclk_in, midi_tx_bit, tx_user, rs_tx_bits, nvb} = {3'h3, 9'h0A5, 2'h3};
    tx_audio = 24'h5A5A5A;
    fmt = fmt_64;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK({led_sync, led_audio}, {FW, FW})
    `CHK(aes_out_pro, 1'b1)
    apb(1'b0, REG_CTRL, 32'h0);
    `CHK(rq, 32'h000000C1)
    apb(1'b0, REG_STAT, 32'h0);
    `CHK(rq[STAT_FW_BIT], 1'b1)
    apb(1'b0, 8'h08, 32'h0);
    `CHK({re, rq}, 33'h100000000)
    foreach (codes[k]) begin
      apb(1'b1, REG_CTRL, {24'h0, codes[k], 6'h01});
      apb(1'b0, REG_CTRL, 32'h0);
      `CHK({rq[7:6], baud_sel}, {2{codes[k]}})
    end
    $display("test registers done");
    // both receivers stalled: buffers fill and refuse
    repeat (6000) @(posedge pclk);
    `CHK({drop_seen, rx_valid, aes_out_valid}, 3'h7)
    aes_out_ready <= 1'b1;
    rx_ready <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, REG_STAT, 32'h0);
    `CHK(rq[STAT_OVR_BIT], 1'b1)
    apb(1'b0, REG_STAT, 32'h0);
    `CHK(rq[6:5], 2'h0)
    $display("test stall done");
    // 96k frame, double wire, word clock at double speed
    fmt <= fmt_96;
    nch <= 32;
    apb(1'b1, REG_CTRL, 32'h00000086);
    aes(6'h05, 24'h111111);
    aes(6'h05, 24'h222222);
    frames(2);
    `CHK({rxw[10], rxw[11]}, {32'h02111111, 32'h02222222})
    `CHK(rxw[27][25:24], 2'h3)
    for (int k = 0; k < 9; k++) `CHK(rxw[k][24], rs_tx_bits[k])
    `CHK({midi_rx_bit, rs_rx_bits, last_aes}, {10'h3FF, 24'h5A5A5A})
    `CHK(stb, 2'h3)
    apb(1'b0, REG_STAT, 32'h0);
    `CHK(rq[3:0], 4'h6)
    $display("test 96k done");
    // 56 channel frame, quad wire, clocked from the word clock at quad speed
    fmt <= fmt_56;
    nch <= 56;
    wc_half <= 130;
    apb(1'b1, REG_CTRL, 32'h000000B8);
    trk <= 1'b1;
    for (int k = 0; k < 4; k++) aes(6'h03, 24'h300000 + 24'(k));
    // the host's first frame after the switch still carries 96k words, so wait for two
    frames(2);
    for (int k = 0; k < 4; k++) `CHK(rxw[12 + k], 32'h00300000 + 32'(k))
    `CHK(rxw[55][25:24], 2'h1)
    `CHK({midi_rx_bit, last_aes}, {1'b1, 24'h5A5A5A})
    `CHK(imax, 6'h0D)
    apb(1'b0, REG_STAT, 32'h0);
    `CHK(rq[4:0], 5'h18)
    $display("test 56 done");
    stop_test();
  end
endmodule : tb_madi_channel_format_mapper
